// *** core/bmu_top.sv ***
// breakpoint match unit: compare, pass count and halt request
`timescale 1ns/1ps
`default_nettype none
// Function
// - an execution breakpoint halts when the core executes the programmed program address.
// - a table-read breakpoint halts when a table read accesses the programmed program address.
// - a table-write breakpoint halts when a table write targets the programmed program address.
// - a data read breakpoint halts on any read of the programmed data address.
// - a data write breakpoint halts on any write to the programmed data address.
// - byte qualified data breakpoints fire only when the data low byte equals the programmed low byte, word ones only when the whole word equals the value.
// - always-break mode halts on every occurrence of the event.
// - delayed mode lets a programmed 1-255 instructions execute after the event, then halts; a count of 0 lets one execute.
// - occurrence mode halts only once the event has occurred the programmed 1-255 times; a count of 0 halts on the first.
// - a breakpoint with its enable clear never requests a halt, and keeps its settings.
module bmu_top
  import bmu_pkg::*;
#(
  parameter int NUM_BP = bmu_pkg::BMU_NUM_BP
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // core instruction activity
  input wire logic instr_exec_i,
  input wire logic [bmu_pkg::BMU_PADDR_W-1:0] instr_addr_i,
  input wire logic table_read_access_i,
  input wire logic table_write_access_i,
  input wire logic [bmu_pkg::BMU_PADDR_W-1:0] table_addr_i,
  // primary data bus
  input wire logic dbus_rd_i,
  input wire logic dbus_wr_i,
  input wire logic [bmu_pkg::BMU_DADDR_W-1:0] dbus_addr_i,
  input wire logic [bmu_pkg::BMU_DATA_W-1:0] dbus_data_i,
  // host configuration, one slot per breakpoint
  input wire logic [NUM_BP-1:0] cfg_wr_i,
  input wire logic [bmu_pkg::BMU_PADDR_W-1:0] cfg_addr_i,
  input wire bmu_pkg::bmu_type_t cfg_type_i,
  input wire bmu_pkg::bmu_pc_mode_t cfg_mode_i,
  input wire logic [bmu_pkg::BMU_CNT_W-1:0] cfg_count_i,
  input wire logic [bmu_pkg::BMU_DATA_W-1:0] cfg_value_i,
  input wire logic cfg_enable_i,
  input wire logic [NUM_BP-1:0] en_set_i,
  input wire logic [NUM_BP-1:0] en_clr_i,
  input wire logic disable_all_i,
  input wire logic halt_ack_i,
  // status and halt
  output logic [NUM_BP-1:0] bp_enabled_o,
  output logic [NUM_BP-1:0] bp_hit_o,
  output logic core_halt_o,
  output logic debug_halt_o
);
  import bmu_pkg::*;

  // =========================================
  // per-breakpoint state
  logic [BMU_PADDR_W-1:0] addr_r [NUM_BP];
  bmu_type_t type_r [NUM_BP];
  bmu_pc_mode_t mode_r [NUM_BP];
  logic [BMU_CNT_W-1:0] count_r [NUM_BP];
  logic [BMU_DATA_W-1:0] value_r [NUM_BP];
  logic [BMU_CNT_W-1:0] pass_r [NUM_BP];
  logic [NUM_BP-1:0] armed_r;
  logic [NUM_BP-1:0] en_r;
  logic [NUM_BP-1:0] hit_r;
  logic [NUM_BP-1:0] fire;
  logic halt_r;
  logic halt_nxt;

  genvar g;
  generate
    for (g = 0; g < NUM_BP; g++) begin : g_bp
      wire [BMU_DADDR_W-1:0] daddr = addr_r[g][BMU_DADDR_W-1:0];
      wire d_addr_hit = (dbus_addr_i == daddr);
      wire byte_eq = (dbus_data_i[7:0] == value_r[g][7:0]);
      wire word_eq = (dbus_data_i == value_r[g]);
      wire hit_exec = instr_exec_i && (instr_addr_i == addr_r[g]);
      wire hit_trd = table_read_access_i && (table_addr_i == addr_r[g]);
      wire hit_twr = table_write_access_i && (table_addr_i == addr_r[g]);
      wire hit_rd = dbus_rd_i && d_addr_hit;
      wire hit_wr = dbus_wr_i && d_addr_hit;
      logic event_w;
      always_comb begin
        unique case (type_r[g])
          BMU_T_EXEC: event_w = hit_exec;
          BMU_T_TBL_RD: event_w = hit_trd;
          BMU_T_TBL_WR: event_w = hit_twr;
          BMU_T_DRD: event_w = hit_rd;
          BMU_T_DRD_BYTE: event_w = hit_rd && byte_eq;
          BMU_T_DRD_WORD: event_w = hit_rd && word_eq;
          BMU_T_DWR: event_w = hit_wr;
          BMU_T_DWR_BYTE: event_w = hit_wr && byte_eq;
          BMU_T_DWR_WORD: event_w = hit_wr && word_eq;
          default: event_w = 1'b0;
        endcase
      end
      // an event counts only while enabled and no halt is pending
      wire ev = event_w && en_r[g] && !halt_r;
      wire pass_zero = (pass_r[g] == BMU_CNT_RST);
      // delayed mode: armed counts executed instructions down
      wire delay_done = armed_r[g] && (pass_zero || (instr_exec_i && pass_r[g] == 8'h01));
      always_comb begin
        unique case (mode_r[g])
          BMU_PC_ALWAYS: fire[g] = ev;
          BMU_PC_DELAY: fire[g] = en_r[g] && !halt_r && delay_done;
          BMU_PC_OCCUR: fire[g] = ev && (pass_zero || pass_r[g] == 8'h01);
          default: fire[g] = 1'b0;
        endcase
      end
      always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
          addr_r[g] <= '0;
          type_r[g] <= BMU_T_EXEC;
          mode_r[g] <= BMU_PC_ALWAYS;
          count_r[g] <= BMU_CNT_RST;
          value_r[g] <= '0;
          pass_r[g] <= BMU_CNT_RST;
          armed_r[g] <= 1'b0;
        end else if (cfg_wr_i[g]) begin
          addr_r[g] <= cfg_addr_i;
          type_r[g] <= cfg_type_i;
          mode_r[g] <= cfg_mode_i;
          count_r[g] <= cfg_count_i;
          value_r[g] <= cfg_value_i;
          pass_r[g] <= cfg_count_i;
          armed_r[g] <= 1'b0;
        end else if (mode_r[g] == BMU_PC_DELAY) begin
          if (fire[g]) begin
            armed_r[g] <= 1'b0;
            pass_r[g] <= count_r[g];
          end else if (armed_r[g] && instr_exec_i) begin
            pass_r[g] <= pass_r[g] - 8'h01;
          end else if (ev) begin
            armed_r[g] <= 1'b1;
          end
        end else if (mode_r[g] == BMU_PC_OCCUR && ev) begin
          // reload after firing so the next run counts afresh
          pass_r[g] <= fire[g] ? count_r[g] : pass_r[g] - 8'h01;
        end
      end
    end
  endgenerate

  // =========================================
  // enables: disable-all keeps every other setting
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      en_r <= '0;
    end else if (disable_all_i) begin
      en_r <= '0;
    end else begin
      en_r <= (en_r & ~en_clr_i) | en_set_i | (cfg_wr_i & {NUM_BP{cfg_enable_i}});
    end
  end

  // =========================================
  // halt request held until the debug side acknowledges
  assign halt_nxt = (|fire) || (halt_r && !halt_ack_i);

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      halt_r <= 1'b0;
      hit_r <= '0;
    end else begin
      halt_r <= halt_nxt;
      // new hit wins over the acknowledge clear
      hit_r <= fire | (halt_ack_i ? '0 : hit_r);
    end
  end

  assign core_halt_o = halt_r;
  assign debug_halt_o = halt_r;
  assign bp_hit_o = hit_r;
  assign bp_enabled_o = en_r;
endmodule
`default_nettype wire

// *** pkg/bmu_pkg.sv ***
// constants and types for the breakpoint match unit
package bmu_pkg;
  // =========================================
  // widths
  localparam int BMU_PADDR_W = 24;
  localparam int BMU_DADDR_W = 16;
  localparam int BMU_DATA_W = 16;
  localparam int BMU_CNT_W = 8;
  localparam int BMU_NUM_BP = 4;
  // =========================================
  // breakpoint types
  typedef enum logic [3:0] {
    BMU_T_EXEC = 4'h0,
    BMU_T_TBL_RD = 4'h1,
    BMU_T_TBL_WR = 4'h2,
    BMU_T_DRD = 4'h3,
    BMU_T_DRD_BYTE = 4'h4,
    BMU_T_DRD_WORD = 4'h5,
    BMU_T_DWR = 4'h6,
    BMU_T_DWR_BYTE = 4'h7,
    BMU_T_DWR_WORD = 4'h8
  } bmu_type_t;
  // =========================================
  // pass count modes
  typedef enum logic [1:0] {
    BMU_PC_ALWAYS = 2'h0,
    BMU_PC_DELAY = 2'h1,
    BMU_PC_OCCUR = 2'h2
  } bmu_pc_mode_t;
  // =========================================
  // reset values
  localparam logic [BMU_CNT_W-1:0] BMU_CNT_RST = 8'h00;
  localparam logic [7:0] BMU_BYTE_MASK = 8'hFF;
endpackage

// *** tb/bmu_core_model.sv ***
// core activity model: linear instruction stream that freezes on halt
`timescale 1ns/1ps
`default_nettype none
module bmu_core_model (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic halt_i,
  output logic exec_o,
  output logic [23:0] pc_o
);
  // no instruction issues while halted, so the pc shows the next one
  assign exec_o = run_i & ~halt_i;
  always_ff @(posedge clk_i) pc_o <= run_i ? pc_o + {23'h0, exec_o} : 24'h0;
endmodule
`default_nettype wire

// *** tb/bmu_top_assertions.sv ***
// halt and enable assertions for the breakpoint match unit
`timescale 1ns/1ps
`default_nettype none
module bmu_top_assertions #(parameter int NUM_BP = 4) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [NUM_BP-1:0] cfg_wr_i,
  input wire logic [NUM_BP-1:0] en_set_i,
  input wire logic [NUM_BP-1:0] en_clr_i,
  input wire logic disable_all_i,
  input wire logic halt_ack_i,
  input wire logic [NUM_BP-1:0] bp_enabled_o,
  input wire logic [NUM_BP-1:0] bp_hit_o,
  input wire logic core_halt_o,
  input wire logic debug_halt_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  a_halt_pair: assert property (core_halt_o == debug_halt_o) else $error("halt pair");
  a_halt_hit: assert property (core_halt_o == (|bp_hit_o)) else $error("halt vs hit");
  a_halt_hold: assert property (core_halt_o && !halt_ack_i |=> core_halt_o) else $error("halt drop");
  a_halt_ack: assert property ($fell(core_halt_o) |-> $past(halt_ack_i)) else $error("halt unacked");
  a_hit_enabled: assert property ($rose(bp_hit_o[0]) |-> $past(bp_enabled_o[0])) else $error("hit off");
  a_en_set: assert property (en_set_i[0] && !disable_all_i |=> bp_enabled_o[0]) else $error("set");
  a_en_clr: assert property (en_clr_i[0] && !en_set_i[0] && !cfg_wr_i[0] |=> !bp_enabled_o[0]) else $error("clr");
  a_dis_all: assert property (disable_all_i |=> bp_enabled_o == '0) else $error("disable all");
endmodule
bind bmu_top bmu_top_assertions #(.NUM_BP(NUM_BP)) bmu_top_assertions_i (.*);
`default_nettype wire

// *** tb/bmu_top_tb.sv ***
// self-checking bench for the breakpoint match unit
`timescale 1ns/1ps
`default_nettype none
module bmu_top_tb;
  import bmu_pkg::*;
  logic ref_clk_i = 0, srst_i = 1, run = 0, ack = 0, dis = 0, exec, halt;
  logic [3:0] ev = 0, cw = 0, es = 0, ec = 0, hit, ena;
  logic dhalt;
  logic [23:0] pc, addr = 0;
  logic [7:0] cnt = 0;
  bmu_type_t ty = BMU_T_EXEC;
  bmu_pc_mode_t md = BMU_PC_ALWAYS;
  int n_fail = 0, samples_checked = 0, cyc = 0;
  bmu_core_model bmu_core_model_i (.clk_i(ref_clk_i), .run_i(run), .halt_i(halt), .exec_o(exec), .pc_o(pc));
  bmu_top bmu_top_i (.ref_clk_i, .srst_i, .instr_exec_i(exec), .instr_addr_i(pc), .table_read_access_i(ev[0]),
    .table_write_access_i(ev[1]), .table_addr_i(addr), .dbus_rd_i(ev[2]), .dbus_wr_i(ev[3]),
    .dbus_addr_i(addr[15:0]), .dbus_data_i(16'h34AB), .cfg_wr_i(cw), .cfg_addr_i(addr), .cfg_type_i(ty),
    .cfg_mode_i(md), .cfg_count_i(cnt), .cfg_value_i(16'h12AB), .cfg_enable_i(1'b1), .en_set_i(es),
    .en_clr_i(ec), .disable_all_i(dis), .halt_ack_i(ack), .bp_enabled_o(ena), .bp_hit_o(hit), .core_halt_o(halt),
    .debug_halt_o(dhalt));
  task automatic chk(input logic [23:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cfg(input bmu_type_t t, input bmu_pc_mode_t m, input logic [7:0] c, input logic [23:0] a);
    @(posedge ref_clk_i) cw <= 4'h1;
    ty <= t;
    md <= m;
    cnt <= c;
    addr <= a;
    @(posedge ref_clk_i) cw <= 4'h0;
  endtask
  task automatic pulse(input int k);
    @(posedge ref_clk_i) ev <= 4'h1 << k;
    @(posedge ref_clk_i) ev <= 4'h0;
  endtask
  task automatic do_ack;
    @(posedge ref_clk_i) ack <= 1'b1;
    run <= 1'b0;
    @(posedge ref_clk_i) ack <= 1'b0;
  endtask
  task automatic ctl(input logic [8:0] v);
    @(posedge ref_clk_i) {dis, es, ec} <= v;
    @(posedge ref_clk_i) {dis, es, ec} <= 9'h0;
  endtask
  // data carries 34AB against 12AB: byte types match, word types must not
  task automatic t_types;
    for (int t = 1; t < 9; t++) begin
      cfg(bmu_type_t'(t), BMU_PC_ALWAYS, 8'h00, 24'h40);
      pulse(t < 3 ? t - 1 : (t < 6 ? 2 : 3));
      #1 chk(24'(halt), 24'(t != 5 && t != 8));
      chk(24'(dhalt), 24'(t != 5 && t != 8));
      do_ack;
    end
  endtask
  task automatic t_run(input bmu_pc_mode_t m, input logic [7:0] c, input logic [23:0] exp);
    cfg(BMU_T_EXEC, m, c, 24'h3);
    @(posedge ref_clk_i) run <= 1'b1;
    #1;
    for (int i = 0; i < 300 && halt !== 1'b1; i++) #20;
    chk(pc, exp);
    do_ack;
  endtask
  task automatic t_occur;
    cfg(BMU_T_TBL_RD, BMU_PC_OCCUR, 8'h03, 24'h40);
    repeat (2) pulse(0);
    #1 chk(24'(halt), 24'h0);
    pulse(0);
    #1 chk(24'(halt), 24'h1);
    chk(24'(hit), 24'h1);
    do_ack;
    #1 chk(24'(hit), 24'h0);
  endtask
  // clear, set, disable all, set again: settings must survive
  task automatic t_enable;
    cfg(BMU_T_DWR, BMU_PC_ALWAYS, 8'h00, 24'h40);
    for (int k = 0; k < 4; k++) begin
      ctl(k[0] ? 9'h010 : (k == 0 ? 9'h001 : 9'h100));
      #1 chk(24'(ena), 24'(k[0]));
      pulse(3);
      #1 chk(24'(halt), 24'(k[0]));
      if (k[0]) do_ack;
    end
  endtask
  initial forever #10 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      stop_test;
    end
  end
  initial begin
    repeat (20) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    t_types;
    t_run(BMU_PC_ALWAYS, 8'h00, 24'h4);
    t_run(BMU_PC_DELAY, 8'h00, 24'h5);
    t_run(BMU_PC_DELAY, 8'hFF, 24'h103);
    t_occur;
    t_enable;
    stop_test;
  end
endmodule
`default_nettype wire
